// [tpm_pkg.sv]
// Package of constants and carriers for the table pointer move unit
package tpm_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int LEN_W = 8;

	// ----------------------------------------
	// Pointer values
	// ----------------------------------------
	localparam logic [15:0] PTR_ZERO = 16'h0000;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [15:0] PTR_FIRST = 16'h0001;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// ----------------------------------------
	// Operations and states
	// ----------------------------------------
	typedef enum logic {
		OP_BOTTOM_POP_MOVE = 1'b0,
		OP_SOURCE_INTO_TABLE = 1'b1
	} tpm_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD_PTR = 3'b001,
		ST_RD_DAT = 3'b010,
		ST_WR_DAT = 3'b011,
		ST_WR_PTR = 3'b100
	} tpm_state_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		tpm_op_t op;
		logic [7:0] len;
		logic [15:0] base;
		logic [15:0] operand;
	} tpm_req_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tpm_mem_cmd_t;

endpackage

// [tpm_table_move.sv]
// Table pointer move unit: pop-from-bottom and source-into-table
`timescale 1ns/1ps

// Notes on behaviour
// (RL1) Pop copies pointer-selected word to destination, then pointer drops by one.
// (RL2) First table word is the pointer, never data; it names next location.
// (RL3) One transfer per start pulse; sequencer pulses once per scan.
// (RL4) Pop with pointer zero moves nothing and keeps the pointer.
// (RL5) Sequencer supplies table length 0 to ff from stack level one.
// (RL6) Sequencer supplies table start address, the pointer word, from accumulator.
// (RL7) Pop destination address comes from the instruction operand.
// (RL8) Pop raises limit flag when pointer equals zero.
// (RL9) Limit flag clears at scan end or when another flag user runs.
// (RL10) Pop never initialises the pointer; the program writes it.
// (RL11) Pop pointer n selects the n-th word after the pointer word.
// (RL12) Source-into-table writes source to selected word, pointer rises by one.
// (RL13) Source-into-table pointer reaching table length wraps to one.
// (RL14) Source-into-table raises limit flag when pointer equals table length.
// (RL15) Source-into-table moves nothing when pointer exceeds table length.
// (RL16) Source-into-table source address comes from the instruction operand.
// (RL17) Source-into-table pointer starts at zero, restored to one at length.
// (RL18) Source-into-table writes data word number pointer modulo length plus one.
// (RL19) Program should gate with a rising edge pulse for single transfers.
// (RL20) Program should set the pointer start once, by first scan or pulse.
// (RL21) All table, pointer, source and destination words are 16-bit memory words.
// (RL22) Done pulses after the pointer write-back, before the next instruction.
module tpm_table_move (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Sequencer request
	input wire logic start,
	input wire tpm_pkg::tpm_req_t req_in,
	input wire logic scan_end,
	input wire logic flag_use,
	// Sequencer answer
	output logic done,
	output logic busy,
	output logic table_limit_flag,
	// Word memory
	output logic mem_req,
	output tpm_pkg::tpm_mem_cmd_t mem_cmd,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	tpm_pkg::tpm_state_t state, next_state;
	tpm_pkg::tpm_req_t req, next_req;
	logic [15:0] ptr, next_ptr;
	logic [15:0] new_ptr, next_new_ptr;
	logic [15:0] data, next_data;
	logic next_mem_req;
	tpm_pkg::tpm_mem_cmd_t next_mem_cmd;
	logic next_done;
	logic next_busy;
	logic next_flag;
	logic flag_set;
	logic flag_clr;
	logic [15:0] len_w;
	logic [15:0] fill_slot;

	assign len_w = {8'h00, req.len};
	// Slot for source-into-table: pointer modulo length plus one
	assign fill_slot = (ptr == len_w) ? tpm_pkg::PTR_FIRST : ptr + tpm_pkg::PTR_STEP; // RL18

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_req = req;
		next_ptr = ptr;
		next_new_ptr = new_ptr;
		next_data = data;
		next_mem_req = mem_req;
		next_mem_cmd = mem_cmd;
		next_done = 1'b0;
		flag_set = 1'b0;
		flag_clr = scan_end | flag_use; // RL9
		case (state)
			tpm_pkg::ST_IDLE: begin
				if (start) begin // RL3
					next_req = req_in;
					flag_clr = 1'b1; // RL9
					next_mem_req = 1'b1;
					next_mem_cmd = '{we: 1'b0, addr: req_in.base, wdata: tpm_pkg::WORD_RST}; // RL2
					next_state = tpm_pkg::ST_RD_PTR;
				end
			end
			tpm_pkg::ST_RD_PTR: begin
				if (mem_ack) begin
					next_ptr = mem_rdata;
					next_mem_req = 1'b0;
					if (req.op == tpm_pkg::OP_BOTTOM_POP_MOVE) begin
						if (mem_rdata == tpm_pkg::PTR_ZERO) begin
							flag_set = 1'b1; // RL8
							next_done = 1'b1; // RL4
							next_state = tpm_pkg::ST_IDLE;
						end else begin
							next_new_ptr = mem_rdata - tpm_pkg::PTR_STEP; // RL1
							flag_set = (mem_rdata == tpm_pkg::PTR_STEP); // RL8
							next_mem_req = 1'b1;
							next_mem_cmd.we = 1'b0;
							next_mem_cmd.addr = req.base + mem_rdata; // RL11
							next_state = tpm_pkg::ST_RD_DAT;
						end
					end else begin
						if (mem_rdata > len_w) begin
							next_done = 1'b1; // RL15
							next_state = tpm_pkg::ST_IDLE;
						end else begin
							if (mem_rdata == len_w) begin
								next_new_ptr = tpm_pkg::PTR_FIRST; // RL13 RL17
							end else begin
								next_new_ptr = mem_rdata + tpm_pkg::PTR_STEP; // RL12
							end
							flag_set = (mem_rdata + tpm_pkg::PTR_STEP == len_w); // RL14
							next_mem_req = 1'b1;
							next_mem_cmd.we = 1'b0;
							next_mem_cmd.addr = req.operand; // RL16
							next_state = tpm_pkg::ST_RD_DAT;
						end
					end
				end
			end
			tpm_pkg::ST_RD_DAT: begin
				if (mem_ack) begin
					next_data = mem_rdata; // RL21
					next_mem_cmd.we = 1'b1;
					next_mem_cmd.wdata = mem_rdata;
					if (req.op == tpm_pkg::OP_BOTTOM_POP_MOVE) begin
						next_mem_cmd.addr = req.operand; // RL7
					end else begin
						next_mem_cmd.addr = req.base + fill_slot; // RL18
					end
					next_state = tpm_pkg::ST_WR_DAT;
				end
			end
			tpm_pkg::ST_WR_DAT: begin
				if (mem_ack) begin
					next_mem_cmd.we = 1'b1;
					next_mem_cmd.addr = req.base; // RL2
					next_mem_cmd.wdata = new_ptr; // RL1 RL12
					next_state = tpm_pkg::ST_WR_PTR;
				end
			end
			tpm_pkg::ST_WR_PTR: begin
				if (mem_ack) begin
					next_mem_req = 1'b0;
					next_mem_cmd.we = 1'b0;
					next_done = 1'b1; // RL22
					next_state = tpm_pkg::ST_IDLE;
				end
			end
			default: begin
				next_mem_req = 1'b0;
				next_state = tpm_pkg::ST_IDLE;
			end
		endcase
		next_busy = (next_state != tpm_pkg::ST_IDLE);
		// Set wins over clear
		if (flag_set) begin
			next_flag = 1'b1; // RL8 RL14
		end else if (flag_clr) begin
			next_flag = 1'b0; // RL9
		end else begin
			next_flag = table_limit_flag;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= tpm_pkg::ST_IDLE;
			req <= '0;
			ptr <= tpm_pkg::WORD_RST;
			new_ptr <= tpm_pkg::WORD_RST;
			data <= tpm_pkg::WORD_RST;
			mem_req <= 1'b0;
			mem_cmd <= '0;
			done <= 1'b0;
			busy <= 1'b0;
			table_limit_flag <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			req <= next_req;
			ptr <= next_ptr;
			new_ptr <= next_new_ptr;
			data <= next_data;
			mem_req <= next_mem_req;
			mem_cmd <= next_mem_cmd;
			done <= next_done;
			busy <= next_busy;
			table_limit_flag <= next_flag;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	chk_done_pulse: assert property ((done && ce) |=> !done) // RL22
		else $error("done held longer than one cycle");

	chk_done_idle: assert property (done |-> !busy) // RL22
		else $error("busy still high with done");

	chk_start_busy: assert property ((ce && state == tpm_pkg::ST_IDLE && start) // RL3
		|=> busy)
		else $error("start not taken while idle");

	chk_start_clear: assert property ((ce && state == tpm_pkg::ST_IDLE && start) // RL9
		|=> !table_limit_flag)
		else $error("limit flag not cleared by start");

	chk_mem_hold: assert property ((ce && mem_req && !mem_ack) // RL21
		|=> (mem_req && $stable(mem_cmd)))
		else $error("memory request changed before acknowledge");

	chk_pop_zero: assert property ((ce && state == tpm_pkg::ST_RD_PTR && mem_ack // RL4
		&& req.op == tpm_pkg::OP_BOTTOM_POP_MOVE && mem_rdata == 16'h0000)
		|=> (done && !mem_req && table_limit_flag))
		else $error("pop with zero pointer did not stop");

	chk_pop_flag: assert property ((ce && state == tpm_pkg::ST_RD_PTR && mem_ack // RL8
		&& req.op == tpm_pkg::OP_BOTTOM_POP_MOVE && mem_rdata == 16'h0001)
		|=> table_limit_flag)
		else $error("limit flag missing when pointer drops to zero");

	chk_pop_dec: assert property ((state == tpm_pkg::ST_WR_PTR && mem_req // RL1
		&& req.op == tpm_pkg::OP_BOTTOM_POP_MOVE) |-> mem_cmd.wdata == ptr - 16'h0001)
		else $error("pop pointer not decremented");

	chk_pop_addr: assert property ((state == tpm_pkg::ST_RD_DAT // RL11
		&& req.op == tpm_pkg::OP_BOTTOM_POP_MOVE) |-> mem_cmd.addr == req.base + ptr)
		else $error("pop read address wrong");

	chk_pop_dest: assert property ((state == tpm_pkg::ST_WR_DAT // RL7
		&& req.op == tpm_pkg::OP_BOTTOM_POP_MOVE)
		|-> (mem_cmd.we && mem_cmd.addr == req.operand && mem_cmd.wdata == data))
		else $error("pop destination write wrong");

	chk_fill_wrap: assert property ((state == tpm_pkg::ST_WR_PTR // RL13
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && ptr == {8'h00, req.len})
		|-> mem_cmd.wdata == 16'h0001)
		else $error("pointer did not wrap to one");

	chk_fill_inc: assert property ((state == tpm_pkg::ST_WR_PTR // RL12
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && ptr < {8'h00, req.len})
		|-> mem_cmd.wdata == ptr + 16'h0001)
		else $error("table pointer not incremented");

	chk_fill_nonzero: assert property ((state == tpm_pkg::ST_WR_PTR // RL17
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE) |-> mem_cmd.wdata != 16'h0000)
		else $error("table pointer written back as zero");

	chk_fill_slot: assert property ((state == tpm_pkg::ST_WR_DAT // RL18
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && ptr < {8'h00, req.len})
		|-> (mem_cmd.we && mem_cmd.addr == req.base + ptr + 16'h0001))
		else $error("table slot address wrong");

	chk_fill_first: assert property ((state == tpm_pkg::ST_WR_DAT // RL18
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && ptr == {8'h00, req.len})
		|-> (mem_cmd.we && mem_cmd.addr == req.base + 16'h0001))
		else $error("wrapped slot is not the first data word");

	chk_fill_range: assert property ((ce && state == tpm_pkg::ST_RD_PTR && mem_ack // RL15
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && mem_rdata > {8'h00, req.len})
		|=> (done && !mem_req))
		else $error("out of range pointer moved data");

	chk_fill_src: assert property ((state == tpm_pkg::ST_RD_DAT // RL16
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE) |-> mem_cmd.addr == req.operand)
		else $error("source address wrong");

	chk_fill_flag: assert property ((ce && state == tpm_pkg::ST_RD_PTR && mem_ack // RL14
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && mem_rdata < {8'h00, req.len}
		&& mem_rdata + 16'h0001 == {8'h00, req.len}) |=> table_limit_flag)
		else $error("limit flag missing at table length");

	chk_flag_clear: assert property ((ce && scan_end && !flag_set) |=> !table_limit_flag) // RL9
		else $error("limit flag survived scan end");

	chk_flag_wins: assert property ((ce && flag_set) |=> table_limit_flag) // RL9
		else $error("limit flag set lost to a clear");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	cov_pop: cover property (done && req.op == tpm_pkg::OP_BOTTOM_POP_MOVE && table_limit_flag);
	cov_wrap: cover property (state == tpm_pkg::ST_WR_PTR && mem_cmd.wdata == 16'h0001
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE && ptr != 16'h0000);
	cov_range: cover property (done && $past(state) == tpm_pkg::ST_RD_PTR
		&& req.op == tpm_pkg::OP_SOURCE_INTO_TABLE);
	cov_set_wins: cover property (ce && flag_set && flag_clr);
	cov_slow_ack: cover property ((mem_req && !mem_ack) [*3] ##1 mem_ack);

endmodule

// [tpm_mem_model.sv]
// Word memory partner with prompt or slow acknowledge
`timescale 1ns/1ps
module tpm_mem_model (
	// Clock and control
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic slow,
	// Memory port
	input wire logic mem_req,
	input wire tpm_pkg::tpm_mem_cmd_t mem_cmd,
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [15:0] mem [0:511];
	logic [15:0] last;
	logic [1:0] cnt;

	// Idle read bus shows the inverse of the last word
	assign mem_rdata = mem_ack ? mem[mem_cmd.addr[8:0]] : ~last;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			cnt <= 2'h0;
			last <= 16'h0000;
		end else if (ce) begin
			mem_ack <= 1'b0;
			if (mem_ack) begin
				cnt <= 2'h0;
				last <= mem_rdata;
				if (mem_cmd.we) begin
					mem[mem_cmd.addr[8:0]] <= mem_cmd.wdata;
				end
			end else if (mem_req) begin
				if (cnt == (slow ? 2'h3 : 2'h0)) begin
					mem_ack <= 1'b1;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end
endmodule

// [test_table_pointer_move_unit.sv]
// Testbench for the table pointer move unit
`timescale 1ns/1ps
module test_table_pointer_move_unit;
	typedef struct packed {
		tpm_pkg::tpm_op_t op;
		logic [7:0] len;
		logic [15:0] ptr;
		logic [15:0] nptr;
		logic [15:0] da;
		logic [15:0] dv;
		logic flg;
	} tpm_row_t;
	localparam tpm_pkg::tpm_op_t P = tpm_pkg::OP_BOTTOM_POP_MOVE;
	localparam tpm_pkg::tpm_op_t S = tpm_pkg::OP_SOURCE_INTO_TABLE;
	localparam logic [15:0] B = 16'h0010;
	localparam logic [15:0] O = 16'h01f0;
	localparam tpm_row_t ROWS [8] = '{
		'{P, 8'h06, 16'h0006, 16'h0005, O, 16'h0a06, 1'b0},
		'{P, 8'h06, 16'h0001, 16'h0000, O, 16'h0a01, 1'b1},
		'{P, 8'h06, 16'h0000, 16'h0000, O, 16'hdead, 1'b1},
		'{S, 8'h06, 16'h0000, 16'h0001, 16'h0011, 16'h5aa5, 1'b0},
		'{S, 8'h06, 16'h0005, 16'h0006, 16'h0016, 16'h5aa5, 1'b1},
		'{S, 8'h06, 16'h0006, 16'h0001, 16'h0011, 16'h5aa5, 1'b0},
		'{S, 8'h06, 16'h0007, 16'h0007, 16'h0011, 16'h0a01, 1'b0},
		'{S, 8'hff, 16'h00fe, 16'h00ff, 16'h010f, 16'h5aa5, 1'b1}
	};
	logic clk, nrst, ce, start, scan_end, flag_use, slow;
	logic done, busy, table_limit_flag, mem_req, mem_ack;
	logic [15:0] mem_rdata;
	tpm_pkg::tpm_req_t req_in;
	tpm_pkg::tpm_mem_cmd_t mem_cmd;
	int n_fail = 0;
	int num_checks = 0;

	tpm_table_move u_tpm_table_move (.clk(clk), .nrst(nrst), .ce(ce), .start(start),
		.req_in(req_in), .scan_end(scan_end), .flag_use(flag_use), .done(done),
		.busy(busy), .table_limit_flag(table_limit_flag), .mem_req(mem_req),
		.mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	tpm_mem_model u_tpm_mem_model (.clk(clk), .nrst(nrst), .ce(ce), .slow(slow),
		.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	// ----
	// Tasks
	// ----
	task chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: bit %b not %b", $time, got, exp);
		end
	endtask
	task chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: word %h not %h", $time, got, exp);
		end
	endtask
	task prep(input tpm_row_t r);
		for (int i = 1; i <= r.len; i++) begin
			u_tpm_mem_model.mem[B + i] = 16'h0a00 + 16'(i);
		end
		u_tpm_mem_model.mem[B] = r.ptr;
		u_tpm_mem_model.mem[O] = (r.op == S) ? 16'h5aa5 : 16'hdead;
	endtask
	task run(input tpm_pkg::tpm_op_t op, input logic [7:0] len, input logic dbl);
		int k;
		req_in = '{op, len, B, O};
		start = 1'b1;
		@(posedge clk) #2 start = 1'b0;
		if (dbl) begin
			@(posedge clk) #2 start = 1'b1;
			@(posedge clk) #2 start = 1'b0;
			ce = 1'b0;
			repeat (3) @(posedge clk);
			#2 chk1(busy, 1'b1);
			ce = 1'b1;
		end
		k = 0;
		while (done !== 1'b1 && k < 200) begin
			@(posedge clk) #2 k++;
		end
		chk1(done, 1'b1);
		chk1(mem_req, 1'b0);
	endtask
	task test_done;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#50000;
		n_fail++;
		test_done;
	end
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		start = 1'b0;
		scan_end = 1'b0;
		flag_use = 1'b0;
		slow = 1'b0;
		req_in = '0;
		repeat (2) @(posedge clk);
		#2 chk1(busy, 1'b0);
		chk1(table_limit_flag, 1'b0);
		chk1(mem_req, 1'b0);
		repeat (2) @(posedge clk);
		#2 nrst = 1'b1;
		foreach (ROWS[r]) begin
			slow = r[0];
			prep(ROWS[r]);
			run(ROWS[r].op, ROWS[r].len, 1'b0);
			chk16(u_tpm_mem_model.mem[B], ROWS[r].nptr);
			chk16(u_tpm_mem_model.mem[ROWS[r].da], ROWS[r].dv);
			chk1(table_limit_flag, ROWS[r].flg);
		end
		scan_end = 1'b1;
		@(posedge clk) #2 scan_end = 1'b0;
		chk1(table_limit_flag, 1'b0);
		prep(ROWS[1]);
		run(P, 8'h06, 1'b0);
		chk1(table_limit_flag, 1'b1);
		flag_use = 1'b1;
		@(posedge clk) #2 flag_use = 1'b0;
		chk1(table_limit_flag, 1'b0);
		scan_end = 1'b1;
		prep(ROWS[2]);
		run(P, 8'h06, 1'b0);
		chk1(table_limit_flag, 1'b1);
		chk16(u_tpm_mem_model.mem[B], 16'h0000);
		scan_end = 1'b0;
		prep(ROWS[3]);
		run(S, 8'h06, 1'b1);
		run(S, 8'h06, 1'b0);
		chk16(u_tpm_mem_model.mem[B], 16'h0002);
		chk16(u_tpm_mem_model.mem[B + 2], 16'h5aa5);
		start = 1'b1;
		@(posedge clk) #2 start = 1'b0;
		@(posedge clk) #2 nrst = 1'b0;
		#2 chk1(busy, 1'b0);
		chk1(mem_req, 1'b0);
		@(posedge clk) #2 nrst = 1'b1;
		repeat (2) @(posedge clk);
		#2 chk1(busy, 1'b0);
		chk1(done, 1'b0);
		chk1(table_limit_flag, 1'b0);
		run(S, 8'h06, 1'b0);
		chk16(u_tpm_mem_model.mem[B], 16'h0003);
		chk16(u_tpm_mem_model.mem[B + 3], 16'h5aa5);
		test_done;
	end
endmodule
